// ==== core/pps_pkg.sv ====
/*
  Constants, codes and helpers for the remappable pin selection block.
  Assumes a 32-bit APB register bus and one system clock.
*/
`default_nettype none
package pps_pkg;
  // --------------------------------------------------------------
  // Field sizes and register map
  // --------------------------------------------------------------
  localparam int CODE_W = 6;
  localparam int SRC_W = 7;
  localparam int ADDR_W = 12;
  localparam int REG_W = 16;
  localparam int NUM_PINS = 4;
  localparam int HI_LSB = 8;
  localparam int LO_LSB = 0;
  localparam logic [ADDR_W-1:0] OFS_CODEC_SEL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PAIR_A = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PAIR_B = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MASK_INPUT_SEL = 16'h7f7f;
  localparam logic [REG_W-1:0] MASK_OUTPUT_SEL = 16'h3f3f;
  localparam logic [31:0] RSV_ALWAYS_ZERO = 32'hffff8080;
  localparam int PIN_113 = 0;
  localparam int PIN_118 = 1;
  localparam int PIN_120 = 2;
  localparam int PIN_125 = 3;
  // --------------------------------------------------------------
  // Output function codes
  // --------------------------------------------------------------
  localparam logic [CODE_W-1:0] FN_DEFAULT_PORT = 6'h00;
  localparam logic [CODE_W-1:0] FN_SERIAL_ONE_TX = 6'h01;
  localparam logic [CODE_W-1:0] FN_SERIAL_TWO_TX = 6'h03;
  localparam logic [CODE_W-1:0] FN_SYNC2_DATA = 6'h08;
  localparam logic [CODE_W-1:0] FN_SYNC2_CLOCK = 6'h09;
  localparam logic [CODE_W-1:0] FN_SYNC2_SELECT = 6'h0a;
  localparam logic [CODE_W-1:0] FN_CODEC_DATA = 6'h0b;
  localparam logic [CODE_W-1:0] FN_CODEC_CLOCK = 6'h0c;
  localparam logic [CODE_W-1:0] FN_CODEC_FRAME = 6'h0d;
  localparam logic [CODE_W-1:0] FN_CAN_ONE_TX = 6'h0e;
  localparam logic [CODE_W-1:0] FN_CAN_TWO_TX = 6'h0f;
  localparam logic [CODE_W-1:0] FN_COMPARE_FIRST = 6'h10;
  localparam logic [CODE_W-1:0] FN_COMPARE_LAST = 6'h17;
  localparam logic [CODE_W-1:0] FN_CMP_FIRST = 6'h18;
  localparam logic [CODE_W-1:0] FN_CMP_SECOND = 6'h19;
  localparam logic [CODE_W-1:0] FN_CMP_THIRD = 6'h1a;
  localparam logic [CODE_W-1:0] FN_SERIAL_THREE_TX = 6'h1b;
  localparam logic [CODE_W-1:0] FN_SERIAL_THREE_RTS = 6'h1c;
  localparam logic [CODE_W-1:0] FN_SERIAL_FOUR_TX = 6'h1d;
  localparam logic [CODE_W-1:0] FN_SERIAL_FOUR_RTS = 6'h1e;
  localparam logic [CODE_W-1:0] FN_SYNC3_DATA = 6'h1f;
  localparam logic [CODE_W-1:0] FN_SYNC3_CLOCK = 6'h20;
  localparam logic [CODE_W-1:0] FN_SYNC3_SELECT = 6'h21;
  localparam logic [CODE_W-1:0] FN_PRIMARY_SYNC = 6'h2d;
  localparam logic [CODE_W-1:0] FN_SECONDARY_SYNC = 6'h2e;
  localparam logic [CODE_W-1:0] FN_ENCODER_ONE_CMP = 6'h2f;
  localparam logic [CODE_W-1:0] FN_ENCODER_TWO_CMP = 6'h30;
  localparam logic [CODE_W-1:0] FN_REFCLK_OUT = 6'h31;
  localparam logic [CODE_W-1:0] FN_CMP_FOURTH = 6'h32;
  localparam logic [CODE_W-1:0] FN_CMP_FIFTH = 6'h33;
  // --------------------------------------------------------------
  // Input source codes
  // --------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_GROUND = 7'h00;
  localparam logic [SRC_W-1:0] SRC_CMP_FIRST = 7'h01;
  localparam int SRC_FIRST_PIN = 2;
  localparam int SRC_LAST_PIN = 124;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_type;

  // Codes that name a real function; all others fall back to the port
  function automatic logic code_assigned(input logic [CODE_W-1:0] code);
    code_assigned = (code == FN_SERIAL_ONE_TX) || (code == FN_SERIAL_TWO_TX) ||
                    ((code >= FN_SYNC2_DATA) && (code <= FN_SYNC3_SELECT)) ||
                    ((code >= FN_PRIMARY_SYNC) && (code <= FN_CMP_FIFTH));
  endfunction
endpackage
`default_nettype wire

// ==== core/output_function_mux.sv ====
/*
  One remappable output pin: picks a peripheral output by function code.
  Assumes the function vector has unassigned codes tied low.
*/
`timescale 1ns/1ps
`default_nettype none
module output_function_mux
  import pps_pkg::*;
(
  input wire logic [CODE_W-1:0] i_code,
  input wire logic [(1<<CODE_W)-1:0] i_functions,
  input wire logic i_port,
  output logic o_value,
  output logic o_from_function
);
  always_comb begin
    o_from_function = code_assigned(i_code);
    // Zero and spare codes hand the pin back to the port
    if (o_from_function) begin
      o_value = i_functions[i_code];
    end else begin
      o_value = i_port;
    end
  end
endmodule
`default_nettype wire

// ==== core/input_source_mux.sv ====
/*
  One remappable peripheral input: picks a source by a 7-bit select.
  Assumes source zero is tied to ground by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module input_source_mux
  import pps_pkg::*;
(
  input wire logic [SRC_W-1:0] i_select,
  input wire logic [(1<<SRC_W)-1:0] i_sources,
  output logic o_value
);
  always_comb begin
    // Selects past the last pin read as ground
    if (i_select <= SRC_W'(SRC_LAST_PIN)) begin
      o_value = i_sources[i_select];
    end else begin
      o_value = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/peripheral_pin_select.sv ====
/*
  Remappable pin selection: four output pins, codec clock and data inputs,
  three selection registers and a status register over APB.
  Assumes peripheral outputs share i_clk; input pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_select
  import pps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_one_transmit,
  input wire logic i_serial_two_transmit,
  input wire logic i_serial_three_transmit,
  input wire logic i_serial_three_request_to_send,
  input wire logic i_serial_four_transmit,
  input wire logic i_serial_four_request_to_send,
  input wire logic i_sync_serial_two_data_out,
  input wire logic i_sync_serial_two_clock_out,
  input wire logic i_sync_serial_two_select,
  input wire logic i_sync_serial_three_data_out,
  input wire logic i_sync_serial_three_clock_out,
  input wire logic i_sync_serial_three_select,
  input wire logic i_codec_data_out,
  input wire logic i_codec_clock,
  input wire logic i_codec_frame_sync,
  input wire logic i_can_one_transmit,
  input wire logic i_can_two_transmit,
  input wire logic [7:0] i_compare_channel,
  input wire logic [4:0] i_comparator_result,
  input wire logic i_primary_timebase_sync,
  input wire logic i_secondary_timebase_sync,
  input wire logic i_encoder_one_compare_out,
  input wire logic i_encoder_two_compare_out,
  input wire logic i_reference_clock_out,
  input wire logic [NUM_PINS-1:0] i_port_out,
  input wire logic [SRC_LAST_PIN:SRC_FIRST_PIN] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_from_function,
  output logic o_codec_clock_in,
  output logic o_codec_data_in
);
  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  logic [REG_W-1:0] codec_sel;
  logic [REG_W-1:0] pair_a;
  logic [REG_W-1:0] pair_b;
  logic [CODE_W-1:0] pin_code [NUM_PINS];
  logic [(1<<CODE_W)-1:0] functions;
  logic [(1<<SRC_W)-1:0] sources;
  logic [SRC_LAST_PIN:SRC_FIRST_PIN] pin_meta;
  logic [SRC_LAST_PIN:SRC_FIRST_PIN] pin_sync;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_from_function;
  logic next_codec_clock;
  logic next_codec_data;
  bus_state_type bus_state;
  logic access;
  logic commit;

  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_CODEC_SEL: reg_index = 2'h0;
      OFS_PAIR_A: reg_index = 2'h1;
      OFS_PAIR_B: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = (addr == OFS_CODEC_SEL) || (addr == OFS_PAIR_A) ||
             (addr == OFS_PAIR_B) || (addr == OFS_STATUS);
  endfunction

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes are dropped
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb,
                                             input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] val;
    val = old;
    if (strb[0]) begin
      val[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      val[15:8] = wdata[15:8];
    end
    merge = val & mask;
  endfunction

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------
  // One wait state: pready rises the cycle after the access phase starts
  assign access = i_psel && i_penable;
  assign commit = access && o_pready;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bus_state <= BUS_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (access) begin
            bus_state <= BUS_ANSWER;
            o_pready <= 1'b1;
            o_pslverr <= !mapped(i_paddr);
            o_prdata <= 32'h0000_0000;
            if (!i_pwrite) begin
              case (reg_index(i_paddr))
                2'h0: o_prdata[REG_W-1:0] <= codec_sel;
                2'h1: o_prdata[REG_W-1:0] <= pair_a;
                2'h2: o_prdata[REG_W-1:0] <= pair_b;
                default: begin
                  if (i_paddr == OFS_STATUS) begin
                    o_prdata[NUM_PINS-1:0] <= o_pin_out;
                    o_prdata[HI_LSB +: NUM_PINS] <= o_pin_from_function;
                  end
                end
              endcase
            end
          end
        end
        BUS_ANSWER: begin
          bus_state <= BUS_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default: begin
          bus_state <= BUS_IDLE;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Selection registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      codec_sel <= REG_RESET;
      pair_a <= REG_RESET;
      pair_b <= REG_RESET;
    end else if (commit && i_pwrite) begin
      case (reg_index(i_paddr))
        2'h0: codec_sel <= merge(codec_sel, i_pwdata, i_pstrb, MASK_INPUT_SEL);
        2'h1: pair_a <= merge(pair_a, i_pwdata, i_pstrb, MASK_OUTPUT_SEL);
        2'h2: pair_b <= merge(pair_b, i_pwdata, i_pstrb, MASK_OUTPUT_SEL);
        default: begin
        end
      endcase
    end
  end

  assign pin_code[PIN_113] = pair_a[LO_LSB +: CODE_W];
  assign pin_code[PIN_118] = pair_a[HI_LSB +: CODE_W];
  assign pin_code[PIN_120] = pair_b[LO_LSB +: CODE_W];
  assign pin_code[PIN_125] = pair_b[HI_LSB +: CODE_W];

  // --------------------------------------------------------------
  // Output function vector
  // --------------------------------------------------------------
  // Unlisted codes stay low but the mux never reads them anyway
  always_comb begin
    functions = '0;
    functions[FN_SERIAL_ONE_TX] = i_serial_one_transmit;
    functions[FN_SERIAL_TWO_TX] = i_serial_two_transmit;
    functions[FN_SERIAL_THREE_TX] = i_serial_three_transmit;
    functions[FN_SERIAL_THREE_RTS] = i_serial_three_request_to_send;
    functions[FN_SERIAL_FOUR_TX] = i_serial_four_transmit;
    functions[FN_SERIAL_FOUR_RTS] = i_serial_four_request_to_send;
    functions[FN_SYNC2_DATA] = i_sync_serial_two_data_out;
    functions[FN_SYNC2_CLOCK] = i_sync_serial_two_clock_out;
    functions[FN_SYNC2_SELECT] = i_sync_serial_two_select;
    functions[FN_SYNC3_DATA] = i_sync_serial_three_data_out;
    functions[FN_SYNC3_CLOCK] = i_sync_serial_three_clock_out;
    functions[FN_SYNC3_SELECT] = i_sync_serial_three_select;
    functions[FN_CODEC_DATA] = i_codec_data_out;
    functions[FN_CODEC_CLOCK] = i_codec_clock;
    functions[FN_CODEC_FRAME] = i_codec_frame_sync;
    functions[FN_CAN_ONE_TX] = i_can_one_transmit;
    functions[FN_CAN_TWO_TX] = i_can_two_transmit;
    functions[FN_COMPARE_LAST:FN_COMPARE_FIRST] = i_compare_channel;
    functions[FN_CMP_FIRST] = i_comparator_result[0];
    functions[FN_CMP_SECOND] = i_comparator_result[1];
    functions[FN_CMP_THIRD] = i_comparator_result[2];
    functions[FN_CMP_FOURTH] = i_comparator_result[3];
    functions[FN_CMP_FIFTH] = i_comparator_result[4];
    functions[FN_PRIMARY_SYNC] = i_primary_timebase_sync;
    functions[FN_SECONDARY_SYNC] = i_secondary_timebase_sync;
    functions[FN_ENCODER_ONE_CMP] = i_encoder_one_compare_out;
    functions[FN_ENCODER_TWO_CMP] = i_encoder_two_compare_out;
    functions[FN_REFCLK_OUT] = i_reference_clock_out;
  end

  // --------------------------------------------------------------
  // Output pins
  // --------------------------------------------------------------
  // The output flop adds one cycle of latency to every routed signal
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    output_function_mux u_mux (
      .i_code(pin_code[p]),
      .i_functions(functions),
      .i_port(i_port_out[p]),
      .o_value(next_pin_out[p]),
      .o_from_function(next_from_function[p])
    );
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pin_out <= '0;
      o_pin_from_function <= '0;
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_from_function <= next_from_function;
    end
  end

  // --------------------------------------------------------------
  // Input pins and codec inputs
  // --------------------------------------------------------------
  // Pins are asynchronous, so two flops guard against metastability
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_comb begin
    sources = '0;
    sources[SRC_GROUND] = 1'b0;
    sources[SRC_CMP_FIRST] = i_comparator_result[0];
    sources[SRC_LAST_PIN:SRC_FIRST_PIN] = pin_sync;
  end

  input_source_mux u_codec_clock (
    .i_select(codec_sel[HI_LSB +: SRC_W]),
    .i_sources(sources),
    .o_value(next_codec_clock)
  );

  input_source_mux u_codec_data (
    .i_select(codec_sel[LO_LSB +: SRC_W]),
    .i_sources(sources),
    .o_value(next_codec_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_codec_clock_in <= 1'b0;
      o_codec_data_in <= 1'b0;
    end else begin
      o_codec_clock_in <= next_codec_clock;
      o_codec_data_in <= next_codec_data;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_default_port;
    !code_assigned(pin_code[PIN_113]) |=> o_pin_out[PIN_113] == $past(i_port_out[PIN_113]);
  endproperty
  a_default_port: assert property (p_default_port) else $error("port not on pin");

  property p_serial_one;
    pin_code[PIN_118] == FN_SERIAL_ONE_TX |=>
      o_pin_out[PIN_118] == $past(i_serial_one_transmit) && o_pin_from_function[PIN_118];
  endproperty
  a_serial_one: assert property (p_serial_one) else $error("serial one not routed");

  property p_serial_four_rts;
    pin_code[PIN_120] == FN_SERIAL_FOUR_RTS |=>
      o_pin_out[PIN_120] == $past(i_serial_four_request_to_send);
  endproperty
  a_serial_four_rts: assert property (p_serial_four_rts) else $error("rts not routed");

  property p_compare_last;
    pin_code[PIN_125] == FN_COMPARE_LAST |=> o_pin_out[PIN_125] == $past(i_compare_channel[7]);
  endproperty
  a_compare_last: assert property (p_compare_last) else $error("compare eight wrong");

  property p_spare_code;
    pin_code[PIN_120] == (FN_SYNC3_SELECT + 6'h01) |=> !o_pin_from_function[PIN_120];
  endproperty
  a_spare_code: assert property (p_spare_code) else $error("spare code drove pin");

  property p_codec_ground;
    codec_sel[LO_LSB +: SRC_W] == SRC_GROUND |=> !o_codec_data_in;
  endproperty
  a_codec_ground: assert property (p_codec_ground) else $error("ground source not low");

  property p_codec_cmp;
    codec_sel[HI_LSB +: SRC_W] == SRC_CMP_FIRST |=>
      o_codec_clock_in == $past(i_comparator_result[0]);
  endproperty
  a_codec_cmp: assert property (p_codec_cmp) else $error("codec clock not comparator");

  property p_reserved_zero;
    o_pready |-> (o_prdata & RSV_ALWAYS_ZERO) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_write_pair_a;
    commit && i_pwrite && i_paddr == OFS_PAIR_A && i_pstrb == 4'hf |=>
      pair_a == ($past(i_pwdata[REG_W-1:0]) & MASK_OUTPUT_SEL);
  endproperty
  a_write_pair_a: assert property (p_write_pair_a) else $error("pair a write lost");

  property p_reset_clear;
    $past(i_sys_rst) |-> pair_a == REG_RESET && pair_b == REG_RESET && codec_sel == REG_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("selection not cleared");

  property p_answer_pulse;
    access && !o_pready |=> o_pready ##1 !o_pready;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse) else $error("pready not one cycle");

  c_write: cover property (commit && i_pwrite);
  c_routed: cover property (o_pin_from_function[PIN_113]);
  c_error: cover property (o_pready && o_pslverr);
endmodule
`default_nettype wire

// ==== dv/peripheral_model.sv ====
/*
  Stand-in for the on-chip peripherals and the remappable input pins.
  Assumes the bench hands it one 32-bit pattern; every level follows it one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
  input wire logic i_clk,
  input wire logic [31:0] i_pattern,
  output logic [63:0] o_fn,
  output logic [124:2] o_pin
);
  // Bit k of o_fn is the output named by function code k; spare codes carry noise on purpose
  always_ff @(posedge i_clk) begin
    o_fn <= {~i_pattern, i_pattern};
    o_pin <= 123'({i_pattern, ~i_pattern, i_pattern ^ 32'h5a5a5a5a, ~i_pattern ^ 32'h0ff0c33c});
  end
endmodule
`default_nettype wire

// ==== dv/peripheral_pin_select_bench.sv ====
/*
  Self-checking bench for the remappable pin selection block.
  Assumes an APB master here, peripheral_model for far-side levels, a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_select_bench;
  import pps_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, seed = 32'he7e7e5f7, pat = '0, rd;
  logic [3:0] pstrb = 4'hf, port = 4'h5;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, clk_in, data_in;
  wire logic [3:0] pin_out, from_fn;
  wire logic [63:0] fn;
  wire logic [124:2] pin;
  int fail_count = 0, n_compared = 0, cycles = 0;
  int sel_tab[6] = '{0, 1, 2, 124, 125, 127};

  initial forever #10 i_clk = ~i_clk;

  peripheral_model i_partner (.i_clk(i_clk), .i_pattern(pat), .o_fn(fn), .o_pin(pin));

  peripheral_pin_select i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_one_transmit(fn[1]), .i_serial_two_transmit(fn[3]),
    .i_serial_three_transmit(fn[27]), .i_serial_three_request_to_send(fn[28]),
    .i_serial_four_transmit(fn[29]), .i_serial_four_request_to_send(fn[30]),
    .i_sync_serial_two_data_out(fn[8]), .i_sync_serial_two_clock_out(fn[9]),
    .i_sync_serial_two_select(fn[10]), .i_sync_serial_three_data_out(fn[31]),
    .i_sync_serial_three_clock_out(fn[32]), .i_sync_serial_three_select(fn[33]),
    .i_codec_data_out(fn[11]), .i_codec_clock(fn[12]), .i_codec_frame_sync(fn[13]),
    .i_can_one_transmit(fn[14]), .i_can_two_transmit(fn[15]),
    .i_compare_channel(fn[23:16]), .i_comparator_result({fn[51:50], fn[26:24]}),
    .i_primary_timebase_sync(fn[45]), .i_secondary_timebase_sync(fn[46]),
    .i_encoder_one_compare_out(fn[47]), .i_encoder_two_compare_out(fn[48]),
    .i_reference_clock_out(fn[49]), .i_port_out(port), .i_pin_in(pin),
    .o_pin_out(pin_out), .o_pin_from_function(from_fn),
    .o_codec_clock_in(clk_in), .o_codec_data_in(data_in));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Codes that name a peripheral output; every other code keeps the port
  function automatic logic known(input int c);
    return c inside {1, 3, [8:33], [45:51]};
  endfunction

  function automatic logic src(input int s);
    return s == 0 ? 1'b0 : s == 1 ? fn[24] : s <= 124 ? pin[s] : 1'b0;
  endfunction

  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on pready with no assumed latency; the bound only guards a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int c, p, s1, s2;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    for (c = 0; c < 3; c++) begin
      apb(0, 12'(c * 4), '0);
      chk(rd, 32'h0);
    end
    chk({28'h0, pin_out}, {28'h0, port});
    pstrb <= 4'h1;
    apb(1, OFS_PAIR_A, '1);
    pstrb <= 4'hf;
    apb(0, OFS_PAIR_A, '0);
    chk(rd, 32'h3f);
    for (c = 0; c < 3; c++) begin
      seed = lfsr(seed);
      apb(1, 12'(c * 4), seed);
      apb(0, 12'(c * 4), '0);
      chk(rd, seed & {16'h0, (c == 0 ? MASK_INPUT_SEL : MASK_OUTPUT_SEL)});
    end
    apb(1, OFS_STATUS, '1);
    chk({31'h0, err}, 32'h0);
    apb(1, 12'h010, '1);
    chk({31'h0, err}, 32'h1);
    apb(0, 12'h010, '0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Every output code, each on one of the four pins, with two opposite patterns
    for (c = 0; c < 64; c++) begin
      p = c % 4;
      seed = lfsr(seed);
      apb(1, p < 2 ? OFS_PAIR_A : OFS_PAIR_B, 32'(c) << (p % 2 ? HI_LSB : LO_LSB));
      for (s1 = 0; s1 < 2; s1++) begin
        pat <= s1 ? ~seed : seed;
        port <= s1 ? ~seed[7:4] : seed[7:4];
        repeat (5) @(posedge i_clk);
        chk({31'h0, pin_out[p]}, {31'h0, known(c) ? fn[c] : port[p]});
        chk({31'h0, from_fn[p]}, {31'h0, known(c)});
      end
    end
    // Input source selects, edge values first
    for (c = 0; c < 24; c++) begin
      seed = lfsr(seed);
      s1 = c < 6 ? sel_tab[c] : int'(seed[7:0]) % 123 + 2;
      s2 = int'(seed[15:9]);
      apb(1, OFS_CODEC_SEL, (32'(s1) << HI_LSB) | 32'(s2));
      pat <= lfsr(seed);
      repeat (6) @(posedge i_clk);
      chk({31'h0, clk_in}, {31'h0, src(s1)});
      chk({31'h0, data_in}, {31'h0, src(s2)});
    end
    // Reset in mid-run clears every selection
    i_sys_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 0;
    for (c = 0; c < 3; c++) begin
      apb(0, 12'(c * 4), '0);
      chk(rd, 32'h0);
    end
    chk({28'h0, from_fn}, 32'h0);
    // Status after reset: every pin back on its port, no function flags, upper bits zero
    apb(0, OFS_STATUS, '0);
    chk(rd, {28'h0, port});
    chk({31'h0, err}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
